// >>> logic/dcp_pkg.sv
package dcp_pkg;

   // ---------------------------------------------------------------
   // clocking and divider counts (clk = 125 MHz)
   // ---------------------------------------------------------------
   localparam int unsigned CLK_MHZ        = 125;
   localparam int unsigned FLASH_HALF     = 4;   // clk cycles per half bit
   localparam int unsigned LED_PRESCALE   = 256; // clk cycles per slot unit
   localparam int unsigned ADC_TICK       = 16;  // clk cycles per ramp unit
   localparam int unsigned ADC_DISCHARGE  = 64;  // ramp units held low

   // ---------------------------------------------------------------
   // flash boot read
   // ---------------------------------------------------------------
   localparam logic [7:0]  FLASH_READ_CMD = 8'h03;
   localparam logic [23:0] FLASH_BOOT_ADR = 24'h000000;
   localparam int unsigned FLASH_HDR_BITS = 32;
   localparam int unsigned FLASH_CFG_BITS = 16;
   localparam logic [15:0] SLOT_LEN_RESET = 16'h0040;

   // ---------------------------------------------------------------
   // control port (i2c target)
   // ---------------------------------------------------------------
   localparam logic [6:0] CTRL_ADDR      = 7'h1b; // arbitrary value
   localparam logic [7:0] REG_CONTROL    = 8'h00;
   localparam logic [7:0] REG_STATUS     = 8'h01;
   localparam logic [7:0] REG_ADC_RESULT = 8'h02;
   localparam int unsigned CTL_LED_EN    = 0;
   localparam int unsigned CTL_ADC_GO    = 1;
   localparam logic [7:0] CONTROL_RESET  = 8'h01;

   // ---------------------------------------------------------------
   // led colour codes
   // ---------------------------------------------------------------
   localparam logic [1:0] LED_NONE  = 2'h0;
   localparam logic [1:0] LED_RED   = 2'h1;
   localparam logic [1:0] LED_GREEN = 2'h2;
   localparam logic [1:0] LED_BLUE  = 2'h3;

   typedef struct packed {
      logic clock;
      logic mosi;
      logic select_n;
      logic spareSelect_n;
   } dcp_flash_t;

   typedef struct packed {
      logic drive;  // level driven when enabled (always low)
      logic oe;     // high while pulling the line low
   } dcp_odpin_t;

endpackage : dcp_pkg

// >>> logic/dcp_sync.sv
`timescale 1ns/1ps
module dcp_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,   // system clock
   input  wire logic         rst_n, // async reset, active low
   input  wire logic [W-1:0] d,     // asynchronous inputs
   output logic      [W-1:0] q      // synchronised outputs
);
   logic [W-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule : dcp_sync

// >>> logic/dcp_periph.sv
`timescale 1ns/1ps
// What this block does
// - LED select steps red, green, blue by the display sequence; 00 is off.
// - LED select stays low during reset and all of auto-initialization.
// - Host interrupt output is not driven while reset is asserted.
// - Two active-low flash port selects; select 0 for flash, select 1 unused.
// - Device masters flash port: drives clock and mosi, receives on miso.
// - Control commands arrive over an open-drain I2C target port.
// - Comparator result drives successive approximation of the ramp drive.
module dcp_periph (
   input  wire logic            clk,                 // 125 MHz clock
   input  wire logic            rst_n,               // controller reset
   output dcp_pkg::dcp_flash_t  flashPort,           // flash port pins
   input  wire logic            flashPortMiso,       // flash data out
   input  wire logic            controlPortSclIn,    // i2c clock level
   output dcp_pkg::dcp_odpin_t  controlPortScl,      // i2c clock drive
   input  wire logic            controlPortSdaIn,    // i2c data level
   output dcp_pkg::dcp_odpin_t  controlPortSda,      // i2c data drive
   output logic                 hostIrqOut,          // host interrupt level
   output logic                 hostIrqOe,           // host interrupt enable
   output logic [1:0]           ledColourSelect,     // led colour code
   input  wire logic            comparatorResultIn,  // sar comparator
   output logic                 thermistorRampDrive, // thermistor_ramp_drive output
   input  wire logic            parkRequest_n        // host park request
);
   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [4:0] pinSync;
   logic       misoS, sclS, sdaS, cmpS, parkS_n;

   dcp_sync #(.W(5)) uPinSync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({flashPortMiso, controlPortSclIn, controlPortSdaIn,
               comparatorResultIn, parkRequest_n}),
      .q     (pinSync)
   );
   assign {misoS, sclS, sdaS, cmpS, parkS_n} = pinSync;

   // ---------------------------------------------------------------
   // boot read from flash
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {BOOT_SELECT, BOOT_SHIFT, BOOT_DONE} dcp_boot_t;
   localparam int unsigned TOTAL_BITS =
      dcp_pkg::FLASH_HDR_BITS + dcp_pkg::FLASH_CFG_BITS;

   dcp_boot_t   boot_q;
   logic [2:0]  halfCnt_q;
   logic [5:0]  bitCnt_q;
   logic [31:0] txShift_q;
   logic [15:0] rxShift_q;
   logic [15:0] slotLen_q;
   logic        initDone_q;
   logic        halfTick;

   // miso is two clocks late; a half bit of four clocks covers it
   assign halfTick = (halfCnt_q == 3'(dcp_pkg::FLASH_HALF - 1));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         halfCnt_q <= '0;
      end else if (halfTick || boot_q != BOOT_SHIFT) begin
         halfCnt_q <= '0;
      end else begin
         halfCnt_q <= halfCnt_q + 3'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         boot_q        <= BOOT_SELECT;
         bitCnt_q      <= '0;
         txShift_q     <= {dcp_pkg::FLASH_READ_CMD, dcp_pkg::FLASH_BOOT_ADR};
         rxShift_q     <= '0;
         slotLen_q     <= dcp_pkg::SLOT_LEN_RESET;
         initDone_q    <= 1'b0;
         flashPort     <= '{clock: 1'b0, mosi: 1'b0,
                            select_n: 1'b1, spareSelect_n: 1'b1};
      end else begin
         case (boot_q)
            BOOT_SELECT: begin
               flashPort.select_n <= 1'b0;
               flashPort.mosi     <= txShift_q[31];
               boot_q             <= BOOT_SHIFT;
            end
            BOOT_SHIFT: begin
               if (halfTick && !flashPort.clock) begin
                  flashPort.clock <= 1'b1;
                  bitCnt_q        <= bitCnt_q + 6'h1;
                  if (bitCnt_q >= 6'(dcp_pkg::FLASH_HDR_BITS)) begin
                     rxShift_q <= {rxShift_q[14:0], misoS};
                  end
               end else if (halfTick) begin
                  flashPort.clock <= 1'b0;
                  txShift_q       <= {txShift_q[30:0], 1'b0};
                  flashPort.mosi  <= txShift_q[30];
                  if (bitCnt_q == 6'(TOTAL_BITS)) begin
                     flashPort.select_n <= 1'b1;
                     flashPort.mosi     <= 1'b0;
                     // zero slot length would stall the sequence
                     slotLen_q  <= (rxShift_q == '0) ? 16'h0001 : rxShift_q;
                     initDone_q <= 1'b1;
                     boot_q     <= BOOT_DONE;
                  end
               end
            end
            BOOT_DONE: begin
               flashPort.select_n <= 1'b1;
            end
            default: boot_q <= BOOT_DONE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // host interrupt
   // ---------------------------------------------------------------
   // released in reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hostIrqOe  <= 1'b0;
         hostIrqOut <= 1'b1;
      end else begin
         hostIrqOe  <= 1'b1;
         hostIrqOut <= ~initDone_q;
      end
   end

   // ---------------------------------------------------------------
   // led colour sequence
   // ---------------------------------------------------------------
   logic [7:0]  control_q;
   logic [7:0]  preCnt_q;
   logic [15:0] slotCnt_q;
   logic        ledRun;

   assign ledRun = initDone_q && parkS_n && control_q[dcp_pkg::CTL_LED_EN];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         preCnt_q        <= '0;
         slotCnt_q       <= '0;
         ledColourSelect <= dcp_pkg::LED_NONE;
      end else if (!ledRun) begin
         preCnt_q        <= '0;
         slotCnt_q       <= '0;
         ledColourSelect <= dcp_pkg::LED_NONE;
      end else if (preCnt_q != 8'(dcp_pkg::LED_PRESCALE - 1)) begin
         preCnt_q <= preCnt_q + 8'h1;
      end else begin
         preCnt_q  <= '0;
         slotCnt_q <= slotCnt_q + 16'h1;
         if (slotCnt_q >= slotLen_q - 16'h1 ||
             ledColourSelect == dcp_pkg::LED_NONE) begin
            slotCnt_q <= '0;
            case (ledColourSelect)
               dcp_pkg::LED_RED:   ledColourSelect <= dcp_pkg::LED_GREEN;
               dcp_pkg::LED_GREEN: ledColourSelect <= dcp_pkg::LED_BLUE;
               default:            ledColourSelect <= dcp_pkg::LED_RED;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // successive approximation thermistor read
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {ADC_IDLE, ADC_DISCH, ADC_RAMP, ADC_TEST}
      dcp_adc_t;

   dcp_adc_t   adc_q;
   logic [3:0] adcPre_q;
   logic [7:0] adcCnt_q;
   logic [7:0] adcMask_q;
   logic [7:0] adcTrial_q;
   logic [7:0] adcResult_q;
   logic       adcStart;
   logic       adcTick;

   assign adcTick = (adcPre_q == 4'(dcp_pkg::ADC_TICK - 1));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         adcPre_q <= '0;
      end else begin
         adcPre_q <= adcTick ? 4'h0 : adcPre_q + 4'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         adc_q               <= ADC_IDLE;
         adcCnt_q            <= '0;
         adcMask_q           <= '0;
         adcTrial_q          <= '0;
         adcResult_q         <= '0;
         thermistorRampDrive <= 1'b0;
      end else begin
         case (adc_q)
            ADC_IDLE: if (adcStart) begin
               adcMask_q  <= 8'h80;
               adcTrial_q <= 8'h80;
               adcCnt_q   <= '0;
               adc_q      <= ADC_DISCH;
            end
            ADC_DISCH: if (adcTick) begin
               thermistorRampDrive <= 1'b0;
               adcCnt_q <= adcCnt_q + 8'h1;
               if (adcCnt_q == 8'(dcp_pkg::ADC_DISCHARGE - 1)) begin
                  adcCnt_q            <= '0;
                  thermistorRampDrive <= 1'b1;
                  adc_q               <= ADC_RAMP;
               end
            end
            ADC_RAMP: if (adcTick) begin
               // ramp height grows with the trial code
               adcCnt_q <= adcCnt_q + 8'h1;
               if (adcCnt_q == adcTrial_q) begin
                  thermistorRampDrive <= 1'b0;
                  adc_q               <= ADC_TEST;
               end
            end
            ADC_TEST: begin
               if (cmpS) begin
                  adcTrial_q <= adcTrial_q & ~adcMask_q | (adcMask_q >> 1);
               end else begin
                  adcTrial_q <= adcTrial_q | (adcMask_q >> 1);
               end
               adcMask_q <= adcMask_q >> 1;
               adcCnt_q  <= '0;
               if (adcMask_q == 8'h01) begin
                  adcResult_q <= cmpS ? (adcTrial_q & 8'hfe) : adcTrial_q;
                  adc_q       <= ADC_IDLE;
               end else begin
                  adc_q <= ADC_DISCH;
               end
            end
            default: adc_q <= ADC_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // control port, i2c target
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {I_IDLE, I_ADDR, I_AACK, I_WR, I_WACK, I_RD,
                             I_RACK} dcp_i2c_t;

   dcp_i2c_t   i2c_q;
   logic       sclP_q, sdaP_q, rnw_q, havePtr_q;
   logic [3:0] iBit_q;
   logic [7:0] iShift_q, ptr_q, rdData;
   logic       iStart, iStop, iRise, iFall;

   assign iStart = sclS && sclP_q && sdaP_q && !sdaS;
   assign iStop  = sclS && sclP_q && !sdaP_q && sdaS;
   assign iRise  = sclS && !sclP_q;
   assign iFall  = !sclS && sclP_q;
   assign adcStart = (i2c_q == I_WR) && iFall && iBit_q == 4'h8 &&
                     havePtr_q && ptr_q == dcp_pkg::REG_CONTROL &&
                     iShift_q[dcp_pkg::CTL_ADC_GO];

   always_comb begin
      case (ptr_q)
         dcp_pkg::REG_CONTROL:    rdData = control_q;
         dcp_pkg::REG_STATUS:     rdData = {6'h00, initDone_q,
                                            adc_q != ADC_IDLE};
         dcp_pkg::REG_ADC_RESULT: rdData = adcResult_q;
         default:                 rdData = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         i2c_q          <= I_IDLE;
         sclP_q         <= 1'b1;
         sdaP_q         <= 1'b1;
         rnw_q          <= 1'b0;
         havePtr_q      <= 1'b0;
         iBit_q         <= '0;
         iShift_q       <= '0;
         ptr_q          <= '0;
         control_q      <= dcp_pkg::CONTROL_RESET;
         controlPortSda <= '{drive: 1'b0, oe: 1'b0};
         controlPortScl <= '{drive: 1'b0, oe: 1'b0};
      end else begin
         sclP_q <= sclS;
         sdaP_q <= sdaS;
         if (iStart) begin
            i2c_q             <= I_ADDR;
            iBit_q            <= '0;
            havePtr_q         <= 1'b0;
            controlPortSda.oe <= 1'b0;
         end else if (iStop) begin
            i2c_q             <= I_IDLE;
            controlPortSda.oe <= 1'b0;
         end else if (iRise) begin
            if (i2c_q == I_ADDR || i2c_q == I_WR) begin
               iShift_q <= {iShift_q[6:0], sdaS};
               iBit_q   <= iBit_q + 4'h1;
            end else if (i2c_q == I_RACK) begin
               rnw_q <= !sdaS;  // reuse: high while master acks
            end
         end else if (iFall) begin
            case (i2c_q)
               I_ADDR: if (iBit_q == 4'h8) begin
                  if (iShift_q[7:1] == dcp_pkg::CTRL_ADDR) begin
                     controlPortSda.oe <= 1'b1;
                     rnw_q             <= iShift_q[0];
                     i2c_q             <= I_AACK;
                  end else begin
                     i2c_q <= I_IDLE;
                  end
               end
               I_AACK, I_RACK: begin
                  if (rnw_q) begin
                     iShift_q          <= {rdData[6:0], 1'b0};
                     controlPortSda.oe <= ~rdData[7];
                     ptr_q             <= ptr_q + 8'h1;
                     iBit_q            <= 4'h1;
                     i2c_q             <= I_RD;
                  end else begin
                     controlPortSda.oe <= 1'b0;
                     iBit_q            <= '0;
                     i2c_q             <= (i2c_q == I_AACK) ? I_WR : I_IDLE;
                  end
               end
               I_WR: if (iBit_q == 4'h8) begin
                  controlPortSda.oe <= 1'b1;
                  havePtr_q         <= 1'b1;
                  i2c_q             <= I_WACK;
                  if (!havePtr_q) begin
                     ptr_q <= iShift_q;
                  end else begin
                     if (ptr_q == dcp_pkg::REG_CONTROL) begin
                        // go bit is a pulse, never stored
                        control_q <= iShift_q &
                           ~(8'h01 << dcp_pkg::CTL_ADC_GO);
                     end
                     ptr_q <= ptr_q + 8'h1;
                  end
               end
               I_WACK: begin
                  controlPortSda.oe <= 1'b0;
                  iBit_q            <= '0;
                  i2c_q             <= I_WR;
               end
               I_RD: begin
                  if (iBit_q == 4'h8) begin
                     controlPortSda.oe <= 1'b0;
                     i2c_q             <= I_RACK;
                  end else begin
                     controlPortSda.oe <= ~iShift_q[7];
                     iShift_q          <= {iShift_q[6:0], 1'b0};
                     iBit_q            <= iBit_q + 4'h1;
                  end
               end
               default: i2c_q <= I_IDLE;
            endcase
         end
      end
   end
endmodule : dcp_periph

// >>> bench/dcp_periph_monitor.sv
`timescale 1ns/1ps
module dcp_periph_monitor (
   input wire logic                clk,                 // clock
   input wire logic                rst_n,               // reset
   input wire dcp_pkg::dcp_flash_t flashPort,           // flash pins
   input wire logic                flashPortMiso,       // flash data
   input wire logic                controlPortSclIn,    // scl level
   input wire dcp_pkg::dcp_odpin_t controlPortScl,      // scl drive
   input wire logic                controlPortSdaIn,    // sda level
   input wire dcp_pkg::dcp_odpin_t controlPortSda,      // sda drive
   input wire logic                hostIrqOut,          // irq level
   input wire logic                hostIrqOe,           // irq enable
   input wire logic [1:0]          ledColourSelect,     // led code
   input wire logic                comparatorResultIn,  // comparator
   input wire logic                thermistorRampDrive, // ramp drive
   input wire logic                parkRequest_n        // park request
);
   default clocking monCb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   chk_reset_outputs: assert property (
      rst_n && !$past(rst_n) |-> !$past(hostIrqOe)
         && $past(ledColourSelect) == dcp_pkg::LED_NONE)
      else $error("irq enable or led active in reset");
   chk_irq_enable: assert property (
      rst_n && $past(rst_n) |-> hostIrqOe)
      else $error("irq not driven after reset");
   chk_led_init_low: assert property (
      hostIrqOut |-> ledColourSelect == dcp_pkg::LED_NONE)
      else $error("led lit during init");
   chk_spare_idle: assert property (
      flashPort.spareSelect_n)
      else $error("spare select asserted");
   chk_flash_clk_idle: assert property (
      flashPort.select_n |-> !flashPort.clock)
      else $error("flash clock runs while deselected");
   chk_flash_half_bit: assert property (
      $rose(flashPort.clock) |-> flashPort.clock[*4] ##1 !flashPort.clock)
      else $error("flash clock high time wrong");
   chk_mosi_hold: assert property (
      flashPort.clock |-> $stable(flashPort.mosi))
      else $error("mosi moved while clock high");
   chk_done_irq: assert property (
      $rose(flashPort.select_n) |-> hostIrqOut ##1 !hostIrqOut)
      else $error("irq did not fall after boot");
   chk_irq_cause: assert property (
      $fell(hostIrqOut) |-> flashPort.select_n && $past(flashPort.select_n))
      else $error("irq fell during boot frame");
   chk_scl_free: assert property (
      !controlPortScl.oe)
      else $error("scl pulled low");
   chk_park_off: assert property (
      (!parkRequest_n)[*5] |-> ledColourSelect == dcp_pkg::LED_NONE)
      else $error("led lit while parked");
endmodule : dcp_periph_monitor

bind dcp_periph dcp_periph_monitor dcp_periph_monitor_i (
   .clk, .rst_n, .flashPort, .flashPortMiso, .controlPortSclIn,
   .controlPortScl, .controlPortSdaIn, .controlPortSda, .hostIrqOut,
   .hostIrqOe, .ledColourSelect, .comparatorResultIn,
   .thermistorRampDrive, .parkRequest_n
);

// >>> bench/dcp_host_model.sv
`timescale 1ns/1ps
module dcp_host_model (
   input  wire logic irqLevel,     // irq wire, pulled up
   input  wire logic sdaWire,      // resolved sda
   output logic      sclRel,       // 1 releases scl
   output logic      sdaRel,       // 1 releases sda
   output logic      parkRequest_n // park request
);
   initial begin
      sclRel = 1'b1;
      sdaRel = 1'b1;
      parkRequest_n = 1'b1;
   end

   task automatic setPark(input logic v);
      if (v || irqLevel === 1'b0)
         parkRequest_n = v;
   endtask : setPark

   task automatic bitx(input logic b, output logic r);
      #20 sdaRel = b;
      #20 sclRel = 1'b1;
      #20 r = sdaWire;
      #20 sclRel = 1'b0;
   endtask : bitx

   task automatic startc;
      sdaRel = 1'b1;
      sclRel = 1'b1;
      #40 sdaRel = 1'b0;
      #40 sclRel = 1'b0;
   endtask : startc

   task automatic stopc;
      #20 sdaRel = 1'b0;
      #20 sclRel = 1'b1;
      #40 sdaRel = 1'b1;
      #40;
   endtask : stopc

   // msb first, ninth bit is ack
   task automatic xbyte(input logic [7:0] d, input logic last,
                        output logic [7:0] r, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         bitx(d[i], b);
         r[i] = b;
      end
      bitx(last, b);
      ack = !b;
   endtask : xbyte

   task automatic wr(input logic [6:0] adr, input logic [7:0] ptr,
                     input logic [7:0] v, output logic ok);
      logic [7:0] r;
      logic a0, a1, a2;
      startc;
      xbyte({adr, 1'b0}, 1'b1, r, a0);
      xbyte(ptr, 1'b1, r, a1);
      xbyte(v, 1'b1, r, a2);
      stopc;
      ok = a0 & a1 & a2;
   endtask : wr

   task automatic rd(input logic [7:0] ptr, output logic [7:0] d,
                     output logic ok);
      logic [7:0] r;
      logic a0, a1, a2;
      startc;
      xbyte({dcp_pkg::CTRL_ADDR, 1'b0}, 1'b1, r, a0);
      xbyte(ptr, 1'b1, r, a1);
      stopc;
      startc;
      xbyte({dcp_pkg::CTRL_ADDR, 1'b1}, 1'b1, r, a2);
      // nack ends the read after one byte
      xbyte(8'hff, 1'b1, d, a1);
      stopc;
      ok = a0 & a2;
   endtask : rd
endmodule : dcp_host_model

// >>> bench/dcp_periph_tb_top.sv
`timescale 1ns/1ps
module dcp_periph_tb_top;
   logic                clk, rst_n, flashPortMiso, comparatorResultIn;
   logic                hostIrqOut, hostIrqOe, thermistorRampDrive;
   logic                sclRel, sdaRel, parkRequest_n, ok, watchLed;
   logic [1:0]          ledColourSelect, prevLed;
   logic [1:0]          expQ[$];
   logic [5:0]          nBits;
   logic [7:0]          rdv, thr;
   logic [15:0]         slot;
   logic [31:0]         cmdSeen;
   int                  miscompares, nChecks, cyc, lastCyc, rampCnt, n;
   dcp_pkg::dcp_flash_t flashPort;
   dcp_pkg::dcp_odpin_t sclDrv, sdaDrv;
   wire sclWire = sclRel & ~sclDrv.oe;
   wire sdaWire = sdaRel & ~sdaDrv.oe;
   // irq line has a pullup while undriven
   wire irqLevel = hostIrqOe ? hostIrqOut : 1'b1;

   dcp_periph dcp_periph_i (
      .clk, .rst_n, .flashPort, .flashPortMiso,
      .controlPortSclIn(sclWire), .controlPortScl(sclDrv),
      .controlPortSdaIn(sdaWire), .controlPortSda(sdaDrv),
      .hostIrqOut, .hostIrqOe, .ledColourSelect, .comparatorResultIn,
      .thermistorRampDrive, .parkRequest_n);
   dcp_host_model dcp_host_model_i (
      .irqLevel, .sdaWire, .sclRel, .sdaRel, .parkRequest_n);

   always #4 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;

   // ---------------------------------------------------------------
   // flash and comparator stand-ins
   // ---------------------------------------------------------------
   always @(posedge flashPort.clock) if (!flashPort.select_n) begin
      if (nBits < 32) cmdSeen <= {cmdSeen[30:0], flashPort.mosi};
      nBits <= nBits + 6'h1;
   end
   always @(negedge flashPort.clock)
      if (!flashPort.select_n && nBits >= 32 && nBits < 48)
         flashPortMiso <= slot[47 - nBits];
   // released data line must not keep its last bit
   always @(posedge flashPort.select_n) flashPortMiso <= ~flashPortMiso;
   always @(posedge clk) rampCnt <= thermistorRampDrive ? rampCnt + 1 : 0;
   always @(posedge clk) comparatorResultIn <= #1 (rampCnt > 16 * thr);

   // ---------------------------------------------------------------
   // checking
   // ---------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      nChecks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", nChecks, miscompares);
      if (miscompares == 0 && nChecks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : report_and_stop

   task automatic expire(input string what);
      $display("ERROR %s expected done seen timeout", what);
      miscompares++;
      report_and_stop;
   endtask : expire

   always @(negedge clk) begin
      prevLed <= ledColourSelect;
      if (watchLed && ledColourSelect !== prevLed) begin
         check("led code", ledColourSelect,
               expQ.size() > 0 ? expQ.pop_front() : 2'bxx);
         if (prevLed != 2'h0 && ledColourSelect != 2'h0)
            check("colour length", cyc - lastCyc,
                  slot * dcp_pkg::LED_PRESCALE);
         lastCyc = cyc;
      end
   end

   initial begin
      repeat (100000) @(posedge clk);
      expire("run");
   end

   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      flashPortMiso = 1'b0;
      comparatorResultIn = 1'b0;
      {nBits, watchLed, miscompares, nChecks, cyc, rampCnt} = '0;
      slot = 16'h1 + 16'($urandom(32'hfa67925e) % 3);
      thr = 8'(1 + $urandom % 200);
      repeat (2) @(posedge clk);
      check("irq enable in reset", hostIrqOe, 1'b0);
      #1 rst_n = 1'b1;
      for (n = 0; n < 5000 && irqLevel !== 1'b0; n++) @(posedge clk);
      if (irqLevel !== 1'b0) expire("boot");
      check("boot command", cmdSeen, 32'h03000000);
      check("boot bits", nBits, 6'h30);
      check("spare select", flashPort.spareSelect_n, 1'b1);
      check("led at init", ledColourSelect, 2'h0);
      $display("boot test done");
      expQ = '{dcp_pkg::LED_RED, dcp_pkg::LED_GREEN, dcp_pkg::LED_BLUE,
               dcp_pkg::LED_RED, dcp_pkg::LED_NONE};
      watchLed = 1'b1;
      for (n = 0; n < 5000 && expQ.size() > 1; n++) @(posedge clk);
      #1 dcp_host_model_i.setPark(1'b0);
      for (n = 0; n < 8 && expQ.size() > 0; n++) @(posedge clk);
      if (expQ.size() > 0) expire("led");
      $display("led test done");
      dcp_host_model_i.rd(dcp_pkg::REG_STATUS, rdv, ok);
      check("status", {ok, rdv}, 9'h102);
      dcp_host_model_i.rd(dcp_pkg::REG_CONTROL, rdv, ok);
      check("control", {ok, rdv}, 9'h101);
      dcp_host_model_i.rd(8'h07, rdv, ok);
      check("unmapped", {ok, rdv}, 9'h100);
      dcp_host_model_i.wr(dcp_pkg::CTRL_ADDR ^ 7'h01, 8'h00, 8'h00, ok);
      check("foreign ack", ok, 1'b0);
      dcp_host_model_i.wr(dcp_pkg::CTRL_ADDR, 8'h00, 8'h02, ok);
      check("start ack", ok, 1'b1);
      dcp_host_model_i.rd(dcp_pkg::REG_STATUS, rdv, ok);
      check("busy", rdv, 8'h03);
      $display("control test done");
      for (n = 0; n < 200 && rdv !== 8'h02; n++)
         dcp_host_model_i.rd(dcp_pkg::REG_STATUS, rdv, ok);
      if (rdv !== 8'h02) expire("adc");
      dcp_host_model_i.rd(dcp_pkg::REG_ADC_RESULT, rdv, ok);
      check("adc result", rdv, thr - 8'h1);
      $display("adc test done");
      report_and_stop;
   end
endmodule : dcp_periph_tb_top
